// ==== design/serial_shift_link.sv ====
// Serial shift register running on the programming clock
`timescale 1ns/1ns
module serial_shift_link (
  // Link clock and reset
  input  wire logic                        programming_clock,
  input  wire logic                        resetn,
  // Serial line
  input  wire logic                        serial_data,
  // Parallel word
  output logic [synth_pkg::SHIFT_W-1:0]    shift_word
);
  import synth_pkg::*;

  logic [SHIFT_W-1:0] shift_ff;

  always_ff @(posedge programming_clock or negedge resetn) begin
    if (!resetn) begin
      shift_ff <= '0;
    end else begin
      shift_ff <= {shift_ff[SHIFT_W-2:0], serial_data};
    end
  end

  assign shift_word = shift_ff;

  a_shift_entry: assert property (
    @(posedge programming_clock) disable iff (!resetn)
    ##1 (shift_ff[0] == $past(serial_data) && shift_ff[1] == $past(shift_ff[0])))
    else $error("serial bit not shifted in");
endmodule

// ==== design/synth_channel_programming.sv ====
// Synthesizer programming, lock indication and path select logic
//
// How it works
// - Transmit active only while transmit select low and receive select high.
// - Receive active only while receive select low and transmit select high.
// - Lock indicator high while locked, low while unlocked; with the lock-output bit set it shows the divided reference frequency.
// - Main divider is 11 bits, legal from 3 to 2047.
// - Swallow value is 7 bits and must stay below the main divider.
// - Reference divider is 14 bits, legal from 3 to 16383.
// - Prescaler 64 or 128; division number is prescaler times main plus swallow.
// - Data bit enters the 19-bit shift register on each clock rise.
// - Strobe rise moves the word into the latch its last bit selects.
`timescale 1ns/1ns
module synth_channel_programming #(
  parameter int SETTLE_CYCLES = synth_pkg::LOCK_SETTLE_CYC
) (
  // System clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         resetn,
  // Programming link
  input  wire logic                         programming_clock,
  input  wire logic                         serial_data,
  input  wire logic                         latch_transfer_strobe,
  // Path select and modulation pins
  input  wire logic                         transmit_path_select_n,
  input  wire logic                         receive_path_select_n,
  input  wire logic                         tx_modulation_input,
  // Lock and path outputs
  output logic                              lock_indicator,
  output logic                              transmit_enable,
  output logic                              receive_enable,
  output logic                              tx_modulation_out,
  // Latched settings
  output logic [synth_pkg::REF_W-1:0]       ref_divider,
  output logic [synth_pkg::MAIN_W-1:0]      main_divider,
  output logic [synth_pkg::SWAL_W-1:0]      swallow_value,
  output logic [synth_pkg::DIVN_W-1:0]      division_number,
  output logic                              prescaler_128,
  output logic                              charge_pump_sel,
  output logic                              lock_output_choice,
  output logic                              phase_polarity_bit,
  output logic                              settings_valid
);
  import synth_pkg::*;

  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

  if (SETTLE_CYCLES < 2) begin : g_chk
    $error("SETTLE_CYCLES must be at least 2");
  end

  // Division number for a prescaler choice, main and swallow values
  function automatic logic [DIVN_W-1:0] div_number(input logic p128, input logic [MAIN_W-1:0] m,
                                                    input logic [SWAL_W-1:0] s);
    div_number = (p128 ? {m, 7'h00} : {1'b0, m, 6'h00}) + {11'h000, s};
  endfunction

  logic [SHIFT_W-1:0] shift_word;
  logic               le_s1_ff, le_s2_ff, le_s3_ff;
  logic               txs_s1_ff, txs_s2_ff, rxs_s1_ff, rxs_s2_ff, mod_s1_ff, mod_s2_ff;
  logic [REF_W-1:0]   ref_ff;
  logic [MAIN_W-1:0]  main_ff;
  logic [SWAL_W-1:0]  swal_ff;
  logic [DIVN_W-1:0]  divn_ff;
  logic               presc_ff, cpump_ff, lds_ff, phase_ff;
  logic               tx_en_ff, rx_en_ff, mod_out_ff, lock_ind_ff, fout_ff;
  logic [REF_W-1:0]   fout_cnt_ff;
  logic [CNT_W-1:0]   settle_ff;
  lock_state_t        state_ff, nxt_state;

  // Shift register lives in the link domain
  serial_shift_link u_shift (
    .programming_clock (programming_clock),
    .resetn            (resetn),
    .serial_data       (serial_data),
    .shift_word        (shift_word)
  );

  // Pin synchronisers; strobe gets a third stage for edge detection
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {le_s1_ff, le_s2_ff, le_s3_ff} <= 3'h0;
      {txs_s1_ff, txs_s2_ff, rxs_s1_ff, rxs_s2_ff} <= 4'hF;
      {mod_s1_ff, mod_s2_ff} <= 2'h0;
    end else begin
      {le_s1_ff, le_s2_ff, le_s3_ff} <= {latch_transfer_strobe, le_s1_ff, le_s2_ff};
      {txs_s1_ff, txs_s2_ff} <= {transmit_path_select_n, txs_s1_ff};
      {rxs_s1_ff, rxs_s2_ff} <= {receive_path_select_n, rxs_s1_ff};
      {mod_s1_ff, mod_s2_ff} <= {tx_modulation_input, mod_s1_ff};
    end
  end

  // Word decode; the shift word is frozen while the strobe is high, so the
  // synchronised strobe edge qualifies the multi-bit crossing
  wire le_rise    = le_s2_ff & ~le_s3_ff;
  wire target_ref = shift_word[TARGET_POS];
  wire [REF_W-1:0]  word_ref  = shift_word[REF_LSB +: REF_W];
  wire [MAIN_W-1:0] word_main = shift_word[MAIN_LSB +: MAIN_W];
  wire [SWAL_W-1:0] word_swal = shift_word[SWAL_LSB +: SWAL_W];

  wire              ld_ref    = le_rise & target_ref;
  wire              ld_cnt    = le_rise & ~target_ref;
  wire [REF_W-1:0]  nxt_ref   = ld_ref ? word_ref : ref_ff;
  wire              nxt_presc = ld_ref ? shift_word[PRESC_POS] : presc_ff;
  wire [MAIN_W-1:0] nxt_main  = ld_cnt ? word_main : main_ff;
  wire [SWAL_W-1:0] nxt_swal  = ld_cnt ? word_swal : swal_ff;

  // range checks on the settings about to be used
  wire nxt_legal = (nxt_ref >= REF_MIN) && (nxt_main >= MAIN_MIN) && ({4'h0, nxt_swal} < nxt_main);
  wire cur_legal = (ref_ff >= REF_MIN) && (main_ff >= MAIN_MIN) && ({4'h0, swal_ff} < main_ff);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ref_ff   <= REF_RST;
      main_ff  <= MAIN_RST;
      swal_ff  <= SWAL_RST;
      divn_ff  <= '0;
      presc_ff <= 1'b0;
      {cpump_ff, lds_ff, phase_ff} <= 3'h0;
    end else begin
      ref_ff   <= nxt_ref;
      main_ff  <= nxt_main;
      swal_ff  <= nxt_swal;
      presc_ff <= nxt_presc;
      // division number follows the latches in the same cycle
      divn_ff  <= div_number(nxt_presc, nxt_main, nxt_swal);
      if (ld_ref) begin
        {cpump_ff, lds_ff, phase_ff} <= {shift_word[CPUMP_POS], shift_word[LDS_POS], shift_word[PHASE_POS]};
      end
    end
  end

  // Lock tracking: a new word that leaves legal settings restarts settling, illegal settings never lock
  wire settle_done = (settle_ff == CNT_W'(SETTLE_CYCLES - 1));
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      UNLOCKED: nxt_state = UNLOCKED;
      SETTLING: nxt_state = settle_done ? LOCKED : SETTLING;
      LOCKED:   nxt_state = LOCKED;
    endcase
    if (le_rise) begin
      nxt_state = nxt_legal ? SETTLING : UNLOCKED;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff  <= UNLOCKED;
      settle_ff <= '0;
    end else begin
      state_ff  <= nxt_state;
      settle_ff <= (le_rise || state_ff != SETTLING) ? '0 : settle_ff + 1'b1;
    end
  end

  // Divided-frequency view for the lock pin when the controller asks for it
  wire fout_wrap = (fout_cnt_ff >= ref_ff - 1'b1) || (ref_ff < REF_MIN);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fout_cnt_ff <= '0;
      fout_ff     <= 1'b0;
    end else begin
      fout_cnt_ff <= fout_wrap ? '0 : fout_cnt_ff + 1'b1;
      fout_ff     <= fout_wrap ? ~fout_ff : fout_ff;
    end
  end

  // path decode; both low or both high selects neither path
  wire tx_cond = ~txs_s2_ff & rxs_s2_ff;
  wire rx_cond = ~rxs_s2_ff & txs_s2_ff;

  // lock pin and registered path outputs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lock_ind_ff <= 1'b0;
      tx_en_ff    <= 1'b0;
      rx_en_ff    <= 1'b0;
      mod_out_ff  <= 1'b0;
    end else begin
      lock_ind_ff <= lds_ff ? fout_ff : (state_ff == LOCKED);
      tx_en_ff    <= tx_cond;
      rx_en_ff    <= rx_cond;
      mod_out_ff  <= mod_s2_ff & tx_cond;  // Modulation only reaches an active transmitter
    end
  end

  assign lock_indicator     = lock_ind_ff;
  assign transmit_enable    = tx_en_ff;
  assign receive_enable     = rx_en_ff;
  assign tx_modulation_out  = mod_out_ff;
  assign ref_divider        = ref_ff;
  assign main_divider       = main_ff;
  assign swallow_value      = swal_ff;
  assign division_number    = divn_ff;
  assign prescaler_128      = presc_ff;
  assign charge_pump_sel    = cpump_ff;
  assign lock_output_choice = lds_ff;
  assign phase_polarity_bit = phase_ff;
  assign settings_valid     = cur_legal;

  // Pin-level conditions seen by the checks
  wire pin_tx = !transmit_path_select_n && receive_path_select_n;
  wire pin_rx = !receive_path_select_n && transmit_path_select_n;

  a_tx_path_pin: assert property (
    @(posedge sys_clk) disable iff (!resetn) pin_tx ##1 pin_tx ##1 pin_tx |-> ##1 transmit_enable)
    else $error("transmit path not enabled");
  a_tx_path_excl: assert property (
    @(posedge sys_clk) disable iff (!resetn) !pin_tx [*3] |-> ##1 !transmit_enable)
    else $error("transmit path enabled wrongly");
  a_rx_path_pin: assert property (
    @(posedge sys_clk) disable iff (!resetn) pin_rx [*3] |-> ##1 receive_enable && !transmit_enable)
    else $error("receive path not enabled");
  a_lock_pin_level: assert property (
    @(posedge sys_clk) disable iff (!resetn) !lds_ff |=> lock_indicator == $past(state_ff == LOCKED))
    else $error("lock pin disagrees with lock state");
  a_main_range_ok: assert property (
    @(posedge sys_clk) disable iff (!resetn) state_ff != UNLOCKED |-> main_ff >= MAIN_MIN)
    else $error("main divider below range while locking");
  a_swallow_below_main: assert property (
    @(posedge sys_clk) disable iff (!resetn) state_ff == LOCKED |-> {4'h0, swal_ff} < main_ff)
    else $error("swallow not below main divider");
  a_ref_range_ok: assert property (
    @(posedge sys_clk) disable iff (!resetn) state_ff != UNLOCKED |-> ref_ff >= REF_MIN)
    else $error("reference divider below range");
  a_division_value: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    division_number == (prescaler_128 ? 18'h00080 : 18'h00040) * main_ff + swal_ff)
    else $error("division number mismatch");
  a_ref_latch_load: assert property (
    @(posedge sys_clk) disable iff (!resetn) le_rise && target_ref |=> ref_ff == $past(word_ref))
    else $error("reference latch not loaded");
  a_cnt_latch_load: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    le_rise && !target_ref |=> main_ff == $past(word_main) && swal_ff == $past(word_swal))
    else $error("counter latch not loaded");

  c_reach_lock:  cover property (@(posedge sys_clk) disable iff (!resetn) state_ff == LOCKED);
  c_ref_load:    cover property (@(posedge sys_clk) disable iff (!resetn) ld_ref);
  c_cnt_load:    cover property (@(posedge sys_clk) disable iff (!resetn) ld_cnt);
  c_tx_on_lock:  cover property (@(posedge sys_clk) disable iff (!resetn) transmit_enable && lock_indicator);
endmodule

// ==== design/synth_pkg.sv ====
// Constants shared by the synthesizer programming block
package synth_pkg;
  // Serial word layout, last bit shifted sits in bit 0
  localparam int SHIFT_W      = 19;
  localparam int TARGET_POS   = 0;
  localparam int REF_LSB      = 1;
  localparam int REF_W        = 14;
  localparam int PRESC_POS    = 15;
  localparam int PHASE_POS    = 16;
  localparam int LDS_POS      = 17;
  localparam int CPUMP_POS    = 18;
  localparam int SWAL_LSB     = 1;
  localparam int SWAL_W       = 7;
  localparam int MAIN_LSB     = 8;
  localparam int MAIN_W       = 11;
  localparam int DIVN_W       = 18;
  // Smallest legal main and reference divider
  localparam logic [REF_W-1:0]  REF_MIN  = 14'h0003;
  localparam logic [MAIN_W-1:0] MAIN_MIN = 11'h003;
  // Reset values of the latched settings
  localparam logic [REF_W-1:0]  REF_RST  = 14'h0000;
  localparam logic [MAIN_W-1:0] MAIN_RST = 11'h000;
  localparam logic [SWAL_W-1:0] SWAL_RST = 7'h00;
  // Timing
  localparam int SYS_CLK_MHZ     = 25;
  localparam int LOCK_SETTLE_US  = 30000;
  localparam int LOCK_SETTLE_CYC = LOCK_SETTLE_US * SYS_CLK_MHZ;
  // Lock tracking states
  typedef enum logic [1:0] {UNLOCKED, SETTLING, LOCKED} lock_state_t;
endpackage

// ==== test/host_ctrl_model.sv ====
// Host controller model driving the synthesizer programming link
`timescale 1ns/1ns
module host_ctrl_model (
  // Programming link
  output logic programming_clock,
  output logic serial_data,
  output logic latch_transfer_strobe
);
  // Idle link at time zero
  initial begin
    programming_clock = 1'b0;
    serial_data = 1'b0;
    latch_transfer_strobe = 1'b0;
  end

  function automatic logic [18:0] ref_word(input logic presc, input logic [13:0] rdiv);
    return {1'b0, 1'b0, 1'b1, presc, rdiv, 1'b1};
  endfunction

  task automatic send_word(input logic [18:0] w);
    #13;
    for (int i = 18; i >= 0; i--) begin
      serial_data = w[i];
      #40 programming_clock = 1'b1;
      #40 programming_clock = 1'b0;
    end
    // Clock stands low; released data inverted so a stale bit never looks valid
    serial_data = ~w[0];
    #40 latch_transfer_strobe = 1'b1;
    #200 latch_transfer_strobe = 1'b0;
    #200;
  endtask
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for synthesizer programming and path select
`timescale 1ns/1ns
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb_top;
  import synth_pkg::*;
  localparam int SETTLE = 20;
  localparam int MOD_HOLD = 2500;  // 100 us at 25 MHz, keeps modulation pulses legal
  logic               sys_clk;
  logic               resetn;
  logic               programming_clock;
  logic               serial_data;
  logic               latch_transfer_strobe;
  logic               transmit_path_select_n;
  logic               receive_path_select_n;
  logic               tx_modulation_input;
  logic               lock_indicator;
  logic               transmit_enable;
  logic               receive_enable;
  logic               tx_modulation_out;
  logic [REF_W-1:0]   ref_divider;
  logic [MAIN_W-1:0]  main_divider;
  logic [SWAL_W-1:0]  swallow_value;
  logic [DIVN_W-1:0]  division_number;
  logic               prescaler_128;
  logic               charge_pump_sel;
  logic               lock_output_choice;
  logic               phase_polarity_bit;
  logic               settings_valid;
  int                 miscompares;
  int                 check_count;
  int                 seed_dummy;
  int                 chan_q[$];

  synth_channel_programming #(.SETTLE_CYCLES(SETTLE)) synth_channel_programming_i (
    .sys_clk, .resetn, .programming_clock, .serial_data, .latch_transfer_strobe,
    .transmit_path_select_n, .receive_path_select_n, .tx_modulation_input,
    .lock_indicator, .transmit_enable, .receive_enable, .tx_modulation_out,
    .ref_divider, .main_divider, .swallow_value, .division_number, .prescaler_128,
    .charge_pump_sel, .lock_output_choice, .phase_polarity_bit, .settings_valid
  );
  host_ctrl_model host_ctrl_model_i (.programming_clock, .serial_data, .latch_transfer_strobe);

  // System clock
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  // Compare and count
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t got %0h exp %0h", $time, g, e);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Reference model settings for one channel, then both words and lock
  task automatic program_channel(input int k);
    int n;
    int m;
    int e_ref;
    n = (868025 + 25 * k - 21700) / 25;
    m = $urandom_range(1) ? 128 : 64;
    e_ref = 21250 / 25;
    @(negedge sys_clk);
    host_ctrl_model_i.send_word(host_ctrl_model_i.ref_word(m == 128, 14'(e_ref)));
    @(negedge sys_clk);
    host_ctrl_model_i.send_word({11'(n / m), 7'(n % m), 1'b0});
    `CHK(ref_divider, e_ref);
    `CHK(main_divider, n / m);
    `CHK(swallow_value, n % m);
    `CHK(prescaler_128, m == 128);
    `CHK(division_number, n);
    `CHK({charge_pump_sel, lock_output_choice, phase_polarity_bit}, 3'h1);
    `CHK(settings_valid, 1);
    `CHK(lock_indicator, 0);
    repeat (SETTLE + 3) @(negedge sys_clk);
    `CHK(lock_indicator, 1);
  endtask

  // Drive pins, wait past the three-edge sync, compare gating
  task automatic set_path(input logic tx_n, input logic rx_n, input logic md);
    @(negedge sys_clk);
    transmit_path_select_n = tx_n;
    receive_path_select_n = rx_n;
    tx_modulation_input = md;
    repeat (5) @(posedge sys_clk);
    #1;
    `CHK(transmit_enable, !tx_n && rx_n);
    `CHK(receive_enable, !rx_n && tx_n);
    `CHK(tx_modulation_out, md && !tx_n && rx_n);
    repeat (MOD_HOLD) @(negedge sys_clk);
  endtask

  // Main sequence
  initial begin
    miscompares = 0;
    check_count = 0;
    resetn = 1'b0;
    transmit_path_select_n = 1'b1;
    receive_path_select_n = 1'b1;
    tx_modulation_input = 1'b0;
    seed_dummy = $urandom(32'h8D98BEBB);
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) resetn = 1'b1;
    `CHK(lock_indicator, 0);
    `CHK(settings_valid, 0);
    for (int k = 0; k < 6; k++) chan_q.push_back($urandom_range(78));
    foreach (chan_q[j]) program_channel(chan_q[j]);
    for (int p = 0; p < 8; p++) set_path(p[0], p[1], p[2]);
    for (int p = 0; p < 6; p++) set_path(1'b0, 1'b1, 1'($urandom_range(1)));
    set_path(1'b1, 1'b0, 1'b0);
    // Swallow not below main must never lock
    @(negedge sys_clk);
    host_ctrl_model_i.send_word({11'h003, 7'h05, 1'b0});
    `CHK(swallow_value, 5);
    `CHK(settings_valid, 0);
    repeat (SETTLE + 5) @(negedge sys_clk);
    `CHK(lock_indicator, 0);
    summarize();
  end

  // Watchdog at about twice the run, which the modulation holds dominate
  initial begin
    #3200000;
    miscompares++;
    summarize();
  end
endmodule
